// ### bench/gpio_pin_config_port_tb.sv
// Self-checking bench for the pin configuration port.
// Assumes the port module, its package, constants header and pin_board.
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
module gpio_pin_config_port_tb;
  import gpio_port_pkg::*;
  logic i_clk, i_reset_n, cfg_wr, latch_wr, set_wr, clear_wr, lock_wr, key, lock_rd, comp_en, lock_act, ready;
  logic [3:0] cfg_pin;
  logic [1:0] fast_sel;
  logic [15:0] latch_data, set_mask, clear_mask, lock_bits, af_out, board, pin, latch, sample, exti, fast_ok, locked;
  pin_cfg_t cfg_data;
  pad_ctrl_t pad;
  int err_total, checks;
  // ****************************************
  // Instances
  // ****************************************
  gpio_pin_config_port #(.RESET_PULL_UP(16'hA010), .RESET_PULL_DOWN(16'h4000), .RESET_PULLED(16'hE010)) u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_wr(cfg_wr), .i_cfg_pin(cfg_pin), .i_cfg_data(cfg_data),
    .i_fast_mode_sel(fast_sel), .i_latch_wr(latch_wr), .i_latch_data(latch_data), .i_set_wr(set_wr),
    .i_set_mask(set_mask), .i_clear_wr(clear_wr), .i_clear_mask(clear_mask), .i_lock_wr(lock_wr),
    .i_lock_key_bit(key), .i_pin_lock_bit(lock_bits), .i_lock_rd(lock_rd), .i_comp_en(comp_en),
    .i_af_out(af_out), .i_pin_in(pin), .o_output_latch(latch), .o_input_sample(sample), .o_pad(pad),
    .o_exti_line(exti), .o_fast_ok(fast_ok), .o_lock_active(lock_act), .o_locked_pins(locked),
    .o_comp_cell_ready(ready));
  pin_board u_board (.i_pad(pad), .i_board(board), .o_pin(pin));
  // Clock and watchdog
  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    err_total++;
    finish_test;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cfg(input logic [3:0] p, input logic [1:0] c, input logic [1:0] s);
    cfg_pin = p;
    cfg_data = '{cfg: c, speed: s};
    cfg_wr = 1'h1;
    tick(1);
    cfg_wr = 1'h0;
    tick(1);
  endtask
  // Kind 0 full write, 1 set, 2 clear
  task automatic lat(input logic [1:0] k, input logic [15:0] d);
    {latch_data, set_mask, clear_mask} = {d, d, d};
    {latch_wr, set_wr, clear_wr} = {k == 2'h0, k == 2'h1, k == 2'h2};
    tick(1);
    {latch_wr, set_wr, clear_wr} = 3'h0;
    tick(1);
  endtask
  task automatic lk(input logic k, input logic rd);
    key = k;
    lock_bits = 16'h0001;
    {lock_wr, lock_rd} = {!rd, rd};
    tick(1);
    {lock_wr, lock_rd} = 2'h0;
    tick(1);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {i_reset_n, cfg_wr, latch_wr, set_wr, clear_wr, lock_wr, key, lock_rd, comp_en, fast_sel} = '0;
    {cfg_pin, cfg_data, latch_data, set_mask, clear_mask, lock_bits, af_out} = '0;
    board = 16'h000A;
    err_total = 0;
    checks = 0;
    tick(5);
    i_reset_n = 1'h1;
    tick(1);
    chk("latch", latch, 16'hA010);
    chk("oe_n", pad.oe_n, 16'hFFFF);
    chk("pull_up", pad.pull_up, 16'hA010);
    chk("pull_down", pad.pull_down, 16'h4000);
    chk("ready", {15'h0, ready}, 16'h0000);
    lat(2'h0, 16'h00A5);
    chk("latch", latch, 16'h00A5);
    lat(2'h1, 16'h0300);
    chk("latch", latch, 16'h03A5);
    lat(2'h2, 16'h0021);
    chk("latch", latch, 16'h0384);
    // Push-pull pin 0 follows its latch bit
    cfg(4'h0, `CFG_OUT_PP, `SPEED_10M);
    chk("oe_n", pad.oe_n, 16'hFFFE);
    lat(2'h1, 16'h0001);
    tick(5);
    chk("out", pad.out & 16'h0001, 16'h0001);
    chk("sample", sample & 16'h0001, 16'h0001);
    chk("exti", exti & 16'h0001, 16'h0000);
    chk("pulls", (pad.pull_up | pad.pull_down) & 16'h0001, 16'h0000);
    chk("schmitt", pad.schmitt_en & 16'h0001, 16'h0001);
    // Open-drain pin 1 against a high board level
    cfg(4'h1, `CFG_OUT_OD, `SPEED_2M);
    tick(5);
    chk("oe_n", pad.oe_n & 16'h0002, 16'h0000);
    chk("sample", sample & 16'h0002, 16'h0000);
    lat(2'h1, 16'h0002);
    tick(5);
    chk("oe_n", pad.oe_n & 16'h0002, 16'h0002);
    chk("sample", sample & 16'h0002, 16'h0002);
    // Alternate function pin 2 at top speed
    cfg(4'h2, `CFG_AF_PP, `SPEED_50M);
    chk("af", pad.out & 16'h0004, 16'h0000);
    chk("fast", fast_ok & 16'h0004, 16'h0000);
    af_out = 16'h0004;
    fast_sel = `FAST_SEL_ON;
    tick(1);
    chk("af", pad.out & 16'h0004, 16'h0004);
    chk("fast", fast_ok & 16'h0004, 16'h0004);
    // Analog pin 3 with the board high
    cfg(4'h3, `CFG_ANALOG, `SPEED_INPUT);
    tick(5);
    chk("sample", sample & 16'h0008, 16'h0000);
    chk("schmitt", pad.schmitt_en & 16'h0008, 16'h0000);
    chk("oe_n", pad.oe_n & 16'h0008, 16'h0008);
    chk("exti", exti & 16'h0008, 16'h0000);
    // Pulled input pin 5, direction from the latch
    cfg(4'h5, `CFG_PULLED, `SPEED_INPUT);
    chk("pull_down", pad.pull_down & 16'h0020, 16'h0020);
    lat(2'h1, 16'h0020);
    chk("pull_up", pad.pull_up & 16'h0020, 16'h0020);
    chk("oe_n", pad.oe_n & 16'h0020, 16'h0020);
    tick(5);
    chk("exti", exti & 16'h0020, 16'h0020);
    // Broken key order, then a good one
    lk(1'h1, 1'h0);
    lk(1'h0, 1'h0);
    lk(1'h0, 1'h0);
    lk(1'h0, 1'h1);
    chk("lock", {15'h0, lock_act}, 16'h0000);
    lk(1'h1, 1'h0);
    lk(1'h0, 1'h0);
    lk(1'h1, 1'h0);
    lk(1'h0, 1'h1);
    chk("lock", {15'h0, lock_act}, 16'h0001);
    chk("locked", locked, 16'h0001);
    cfg(4'h0, `CFG_ANALOG, `SPEED_INPUT);
    cfg(4'h6, `CFG_OUT_PP, `SPEED_10M);
    chk("oe_n", pad.oe_n & 16'h0041, 16'h0000);
    // Compensation cell settles after enable, wanted by fast pin 2
    comp_en = 1'h1;
    tick(19);
    chk("ready", {15'h0, ready}, 16'h0000);
    tick(1);
    chk("ready", {15'h0, ready}, 16'h0001);
    comp_en = 1'h0;
    tick(1);
    chk("ready", {15'h0, ready}, 16'h0000);
    // Reset in mid-run releases the lock
    i_reset_n = 1'h0;
    tick(2);
    i_reset_n = 1'h1;
    tick(1);
    chk("lock", {15'h0, lock_act}, 16'h0000);
    chk("locked", locked, 16'h0000);
    chk("oe_n", pad.oe_n, 16'hFFFF);
    cfg(4'h0, `CFG_ANALOG, `SPEED_INPUT);
    chk("schmitt", pad.schmitt_en & 16'h0001, 16'h0000);
    finish_test;
  end
endmodule // gpio_pin_config_port_tb

// ### bench/pin_board.sv
// Board model: resolves each pin from pad drive, weak pulls and a board level.
// Assumes the pad controls of the pin port; oe_n low means the pad drives.
`timescale 1ns/1ps
module pin_board (
  input wire gpio_port_pkg::pad_ctrl_t i_pad,
  input wire logic [15:0] i_board,
  output logic [15:0] o_pin
);
  import gpio_port_pkg::*;
  // ****************************************
  // Pin resolution
  // ****************************************
  // Driver beats pulls, pulls beat the board level
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      if (!i_pad.oe_n[n]) o_pin[n] = i_pad.out[n];
      else if (i_pad.pull_up[n]) o_pin[n] = 1'h1;
      else if (i_pad.pull_down[n]) o_pin[n] = 1'h0;
      else o_pin[n] = i_board[n];
    end
  end
endmodule // pin_board

// ### rtl/gpio_pin_config_port.sv
// Pin configuration port: modes, latch, atomic set/clear, lock, compensation.
// Assumes pins pass through pads controlled here; software strobes are one-cycle pulses.
`timescale 1ns/1ps
`include "gpio_port_consts.svh"

// Operation
// - Speed 00 is input: cfg 00 analog, 01 floating, 10 pulled per latch.
// - Nonzero speed: cfg 00 push-pull, 01 open-drain, 10/11 alternate function.
// - Speed 01 10MHz, 10 2MHz, 11 50MHz; fastest needs fast select 11.
// - After reset ordinary pins are floating inputs with alternate functions off.
// - Debug pins reset pulled: 15,13,4 up, 14 down, 3 floating.
// - Pin levels are sampled into the input register every clock.
// - General output drives the pin from its latch bit.
// - Set and clear writes affect only the bits written as one.
// - Interrupt lines see a pin only in input mode.
// - Input mode: Schmitt on, pull selectable, output buffer off.
// - General output: buffer and Schmitt on, pulls off.
// - Open-drain: latch 0 drives low, 1 releases.
// - Push-pull: latch 0 drives low, 1 drives high.
// - Latch reads last written value; input register reads sampled pins.
// - Analog: pulls, buffer and Schmitt off; input bit reads zero.
// - Alternate function: peripheral drives the buffer instead of the latch.
// - Completed lock sequence freezes locked pins' configuration until reset.
// - Compensation off after reset; ready flag rises once enabled.
module gpio_pin_config_port #(
  parameter int PINS = `PIN_COUNT,
  parameter logic [15:0] RESET_PULL_UP = 16'h0000,
  parameter logic [15:0] RESET_PULL_DOWN = 16'h0000,
  parameter logic [15:0] RESET_PULLED = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cfg_wr,
  input wire logic [3:0] i_cfg_pin,
  input wire gpio_port_pkg::pin_cfg_t i_cfg_data,
  input wire logic [1:0] i_fast_mode_sel,
  input wire logic i_latch_wr,
  input wire logic [15:0] i_latch_data,
  input wire logic i_set_wr,
  input wire logic [15:0] i_set_mask,
  input wire logic i_clear_wr,
  input wire logic [15:0] i_clear_mask,
  input wire logic i_lock_wr,
  input wire logic i_lock_key_bit,
  input wire logic [15:0] i_pin_lock_bit,
  input wire logic i_lock_rd,
  input wire logic i_comp_en,
  input wire logic [15:0] i_af_out,
  input wire logic [15:0] i_pin_in,
  output logic [15:0] o_output_latch,
  output logic [15:0] o_input_sample,
  output gpio_port_pkg::pad_ctrl_t o_pad,
  output logic [15:0] o_exti_line,
  output logic [15:0] o_fast_ok,
  output logic o_lock_active,
  output logic [15:0] o_locked_pins,
  output logic o_comp_cell_ready
);
  import gpio_port_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  pin_cfg_t cfg_q [PINS];
  // Pins that come up pulled, with the latch choosing the direction
  localparam logic [15:0] RESET_PULL_ANY = RESET_PULLED | RESET_PULL_UP | RESET_PULL_DOWN;
  logic [15:0] latch_q, latch_d;
  logic [15:0] sync1_q, sync2_q, sync3_q, stable_q;
  lock_state_t lk_q, lk_d;
  logic [15:0] lk_bits_q;
  logic lock_q;
  logic [15:0] locked_q;
  logic [5:0] comp_cnt_q;
  logic comp_rdy_q;

  // ****************************************
  // Mode decode per pin
  // ****************************************
  logic [15:0] is_input, is_analog, is_pulled, is_af, is_od, is_out;
  logic [15:0] pad_drive, pad_oe_n, pu, pd, st_en;

  function automatic logic mode_in(input pin_cfg_t c);
    mode_in = (c.speed == `SPEED_INPUT);
  endfunction

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // Decode of mode and speed fields
      assign is_input[g] = mode_in(cfg_q[g]);
      assign is_analog[g] = is_input[g] && cfg_q[g].cfg == `CFG_ANALOG;
      assign is_pulled[g] = is_input[g] && cfg_q[g].cfg == `CFG_PULLED;
      assign is_af[g] = !is_input[g] && cfg_q[g].cfg[1];
      assign is_od[g] = !is_input[g] && cfg_q[g].cfg[0];
      assign is_out[g] = !is_input[g];
      // Highest speed only valid with fast select set
      assign o_fast_ok[g] = cfg_q[g].speed != `SPEED_50M || i_fast_mode_sel == `FAST_SEL_ON;
      // Drive source: peripheral or latch
      assign pad_drive[g] = is_af[g] ? i_af_out[g] : latch_q[g];
      // Open-drain releases on one, push-pull always drives
      assign pad_oe_n[g] = !is_out[g] || (is_od[g] && pad_drive[g]);
      assign pu[g] = is_pulled[g] && latch_q[g];
      assign pd[g] = is_pulled[g] && !latch_q[g];
      assign st_en[g] = !is_analog[g];
    end
  endgenerate

  // Pad bundle and interrupt routing
  assign o_pad = '{out: pad_drive & ~{16{1'b0}}, oe_n: pad_oe_n, pull_up: pu, pull_down: pd, schmitt_en: st_en};
  assign o_exti_line = stable_q & is_input & ~is_analog;

  // ****************************************
  // Pin sampling
  // ****************************************
  // Three-stage synchroniser, accept when last two agree
  always_ff @(posedge i_clk) begin
    sync1_q <= i_pin_in;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      stable_q <= 16'h0000;
    end else begin
      stable_q <= (sync2_q & sync3_q) | (stable_q & (sync2_q ^ sync3_q));
    end
  end
  // Input register updated every clock, analog reads zero
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_input_sample <= 16'h0000;
    end else begin
      o_input_sample <= stable_q & ~is_analog;
    end
  end

  // ****************************************
  // Output latch
  // ****************************************
  // Full write, then atomic clear, then set
  always_comb begin
    latch_d = latch_q;
    if (i_latch_wr) begin
      latch_d = i_latch_data;
    end
    if (i_clear_wr) begin
      latch_d = latch_d & ~i_clear_mask;
    end
    if (i_set_wr) begin
      latch_d = latch_d | i_set_mask;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      latch_q <= RESET_PULL_UP;
    end else begin
      latch_q <= latch_d;
    end
  end
  assign o_output_latch = latch_q;

  // ****************************************
  // Configuration fields
  // ****************************************
  // Writes to frozen pins are dropped
  wire cfg_take = i_cfg_wr && !locked_q[i_cfg_pin];
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (int i = 0; i < PINS; i++) begin
        cfg_q[i] <= RESET_PULL_ANY[i] ? pin_cfg_t'({`CFG_PULLED, `SPEED_INPUT}) : pin_cfg_t'(`PIN_CFG_RESET);
      end
    end else if (cfg_take) begin
      cfg_q[i_cfg_pin] <= i_cfg_data;
    end
  end

  // ****************************************
  // Lock key sequence
  // ****************************************
  // Key 1, 0, 1 with matching lock bits, then a read
  wire same_bits = i_pin_lock_bit == lk_bits_q;
  always_comb begin
    lk_d = lk_q;
    case (lk_q)
      LK_IDLE: begin
        if (i_lock_wr && i_lock_key_bit) lk_d = LK_ONE;
      end
      LK_ONE: begin
        if (i_lock_wr) lk_d = (!i_lock_key_bit && same_bits) ? LK_ZERO : LK_IDLE;
        else if (i_lock_rd) lk_d = LK_IDLE;
      end
      LK_ZERO: begin
        if (i_lock_wr) lk_d = (i_lock_key_bit && same_bits) ? LK_ONE2 : LK_IDLE;
        else if (i_lock_rd) lk_d = LK_IDLE;
      end
      LK_ONE2: begin
        if (i_lock_wr || i_lock_rd) lk_d = LK_IDLE;
      end
      default: lk_d = LK_IDLE;
    endcase
  end
  wire lock_done = (lk_q == LK_ONE2) && i_lock_rd && !i_lock_wr;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      lk_q <= LK_IDLE;
      lk_bits_q <= 16'h0000;
      lock_q <= 1'b0;
      locked_q <= 16'h0000;
    end else begin
      lk_q <= lock_q ? LK_IDLE : lk_d;
      if (i_lock_wr) lk_bits_q <= i_pin_lock_bit;
      if (lock_done && !lock_q) begin
        lock_q <= 1'b1;
        locked_q <= lk_bits_q;
      end
    end
  end
  assign o_lock_active = lock_q;
  assign o_locked_pins = locked_q;

  // ****************************************
  // Compensation cell
  // ****************************************
  // Ready after a settling count once enabled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_comp_en) begin
      comp_cnt_q <= 6'h00;
      comp_rdy_q <= 1'b0;
    end else if (comp_cnt_q == 6'(`COMP_SETTLE_CYC - 1)) begin
      comp_rdy_q <= 1'b1;
    end else begin
      comp_cnt_q <= comp_cnt_q + 6'h01;
    end
  end
  assign o_comp_cell_ready = comp_rdy_q;

  // ****************************************
  // Checks
  // ****************************************
  // Cycles that the compensation enable has stood high
  logic [5:0] en_run_q;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_comp_en) begin
      en_run_q <= 6'h00;
    end else if (en_run_q != 6'h3F) begin
      en_run_q <= en_run_q + 6'h01;
    end
  end
  a_set_clear_mask: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_set_wr && !i_latch_wr && !i_clear_wr) |=> ((latch_q & $past(i_set_mask)) == $past(i_set_mask)
      && (latch_q & ~$past(i_set_mask)) == ($past(latch_q) & ~$past(i_set_mask))))
    else $error("set write disturbed other bits");
  a_clear_bits: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clear_wr && !i_set_wr && !i_latch_wr) |=> (latch_q & $past(i_clear_mask)) == 16'h0000)
    else $error("clear write left bits set");
  a_analog_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_input_sample & is_analog & $past(is_analog)) == 16'h0000)
    else $error("analog pin reads one");
  a_analog_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (is_analog & (st_en | pu | pd | ~pad_oe_n)) == 16'h0000)
    else $error("analog pin pad not idle");
  a_input_no_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (pad_oe_n | ~is_input) == 16'hFFFF)
    else $error("input pin driven");
  a_pull_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (is_pulled & ~(pu ^ pd)) == 16'h0000)
    else $error("pulled input without exactly one pull");
  a_od_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ((is_od & ~is_af & latch_q) & ~pad_oe_n) == 16'h0000)
    else $error("open drain drives high");
  a_pp_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ((is_out & ~is_od) & pad_oe_n) == 16'h0000)
    else $error("push pull not driving");
  a_gp_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ((is_out & ~is_af) & (pad_drive ^ latch_q)) == 16'h0000)
    else $error("output pin not following latch");
  a_af_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (is_af & (pad_drive ^ i_af_out)) == 16'h0000)
    else $error("alternate pin not following peripheral");
  a_out_no_pull: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ((pu | pd) & is_out) == 16'h0000)
    else $error("pull on output");
  a_exti_input: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_exti_line & is_out) == 16'h0000)
    else $error("interrupt from output pin");
  sequence s_lock_done;
    lock_done ##1 1'b1;
  endsequence
  a_lock_freeze: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (lock_q && i_cfg_wr && locked_q[i_cfg_pin]) |=> cfg_q[$past(i_cfg_pin)] == $past(cfg_q[i_cfg_pin]))
    else $error("locked config changed");
  a_lock_sets: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s_lock_done) |-> lock_q)
    else $error("lock not taken");
  a_lock_abort: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (lk_q == LK_ZERO && i_lock_wr && !i_lock_key_bit) |=> lk_q == LK_IDLE)
    else $error("broken key order not aborted");
  a_comp_ready: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_comp_cell_ready == (en_run_q >= 6'(`COMP_SETTLE_CYC)))
    else $error("compensation ready at wrong time");
  a_comp_drop: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_comp_en |=> !o_comp_cell_ready)
    else $error("compensation ready while disabled");
endmodule // gpio_pin_config_port

// ### rtl/gpio_port_consts.svh
// Constants for the pin configuration port: field codes, reset values, counts.
// Assumes inclusion by bare name from the package and the port module.
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH
`define PIN_COUNT 16
`define CFG_ANALOG 2'h0
`define CFG_FLOAT 2'h1
`define CFG_PULLED 2'h2
`define CFG_OUT_PP 2'h0
`define CFG_OUT_OD 2'h1
`define CFG_AF_PP 2'h2
`define CFG_AF_OD 2'h3
`define SPEED_INPUT 2'h0
`define SPEED_10M 2'h1
`define SPEED_2M 2'h2
`define SPEED_50M 2'h3
`define FAST_SEL_ON 2'h3
`define PIN_CFG_RESET 4'h4
`define COMP_SETTLE_NS 1000
`define CLK_PERIOD_NS 50
`define COMP_SETTLE_CYC ((`COMP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### rtl/gpio_port_pkg.sv
// Types for the pin configuration port.
// Assumes gpio_port_consts.svh is on the include path.
`include "gpio_port_consts.svh"
package gpio_port_pkg;
  // Per-pin configuration: mode field above speed field
  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] speed;
  } pin_cfg_t;
  // Pad controls for all pins
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe_n;
    logic [15:0] pull_up;
    logic [15:0] pull_down;
    logic [15:0] schmitt_en;
  } pad_ctrl_t;
  typedef enum logic [1:0] {LK_IDLE, LK_ONE, LK_ZERO, LK_ONE2} lock_state_t;
endpackage
